// ### repeater_mode_load_config.v
// Function
// RULE1: Security bit 0 sets all port enables
// RULE2: Gap bit selects 5 or 3 bit times
// RULE3: Collision limit 63 or 31 consecutive collisions
// RULE4: Bit 0 partitions ports lacking loopback
// RULE5: Bit 0 counts out-of-window collisions
// RULE6: Bit 0 restricts segment reconnection
// RULE7: Bit 0 disables all partition machines
// RULE8: Display minimum mode on 0, maximum on 1
// RULE9: Bypass bits choose internal transceiver ports
// RULE10: Bus polarity high on 0, low on 1
// RULE11: Decoder external on 0, internal PLL on 1
// RULE12: Loader must present 1 on reserved pin
// RULE13: Options captured on strobe rising edge
// RULE14: Strobe low holds repeater logic in reset
// RULE15: Captured options held until next load
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "repeater_mode_load_config_defines.vh"

module repeater_mode_load_config (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Configuration pins
    input  wire        config_load_strobe_n,
    input  wire [7:0]  cfg_data_pins,
    input  wire [4:0]  cfg_addr_pins,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    // AXI4-Lite read data
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // Repeater core reset
    output reg         core_reset_n,
    // Static options
    output reg         security_select,
    output reg  [2:0]  gap_time_bits,
    output reg  [5:0]  collision_limit,
    output reg         loopback_partition_enable,
    output reg         late_collision_count_enable,
    output reg         restricted_reconnect_enable,
    output reg         partition_disable,
    output reg         display_max_mode,
    output reg  [11:0] internal_transceiver_ports,
    output reg         bus_polarity_select,
    output reg         decoder_source_select,
    output reg         reserved_option_error,
    // Port security configuration, bit n is port n+1
    output reg  [12:0] learn_enable,
    output reg  [12:0] security_enable,
    output reg  [12:0] source_check_enable,
    output reg  [12:0] dest_check_enable
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    wire       strobe_sync;
    wire [7:0] data_sync;
    wire [4:0] addr_sync;
    reg        strobe_prev_q;
    wire       load_edge;

    // Strobe resets high so a strobe already released at reset gives no false load
    pin_sync #(
        .WIDTH   (1),
        .RST_VAL (1'b1)
    ) u_strobe_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin_in     (config_load_strobe_n),
        .pin_sync_q (strobe_sync)
    );

    // Options travel the same depth as the strobe, so the capture sees them aligned
    pin_sync #(
        .WIDTH   (13),
        .RST_VAL (1'b0)
    ) u_option_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin_in     ({cfg_addr_pins, cfg_data_pins}),
        .pin_sync_q ({addr_sync, data_sync})
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            strobe_prev_q <= 1'b1;
        end else begin
            strobe_prev_q <= strobe_sync;
        end
    end

    assign load_edge = strobe_sync & ~strobe_prev_q; // RULE13

    // ****************************************************************
    // Option capture
    // ****************************************************************
    reg [7:0] cfg_data_q;
    reg [4:0] cfg_addr_q;
    reg       loaded_q;
    reg [7:0] load_count_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cfg_data_q   <= `RST_CFG_DATA;
            cfg_addr_q   <= `RST_CFG_ADDR;
            loaded_q     <= 1'b0;
            load_count_q <= 8'h00;
        end else if (load_edge) begin
            cfg_data_q   <= data_sync; // RULE13
            cfg_addr_q   <= addr_sync; // RULE13
            loaded_q     <= 1'b1;
            load_count_q <= load_count_q + 8'h01;
        end
    end

    // Repeater logic stays in reset while the strobe is low or the bus reset is on
    always @(posedge aclk) begin
        if (!aresetn) begin
            core_reset_n <= 1'b0;
        end else begin
            core_reset_n <= strobe_sync; // RULE14
        end
    end

    // ****************************************************************
    // Decoded options
    // ****************************************************************
    // All outputs follow the captured copy only, so they move solely after a load
    always @(posedge aclk) begin
        if (!aresetn) begin
            security_select             <= 1'b1;
            gap_time_bits               <= `GAP_BITS_SHORT;
            collision_limit             <= `COLL_LIMIT_LOW;
            loopback_partition_enable   <= 1'b0;
            late_collision_count_enable <= 1'b0;
            restricted_reconnect_enable <= 1'b0;
            partition_disable           <= 1'b0;
            display_max_mode            <= 1'b1;
            bus_polarity_select         <= 1'b1;
            decoder_source_select       <= 1'b1;
            reserved_option_error       <= 1'b0;
        end else begin
            security_select             <= cfg_data_q[`BIT_SECURITY]; // RULE15
            gap_time_bits               <= cfg_data_q[`BIT_GAP_TIME] ?
                                           `GAP_BITS_SHORT : `GAP_BITS_LONG; // RULE2
            collision_limit             <= cfg_data_q[`BIT_COLL_LIMIT] ?
                                           `COLL_LIMIT_LOW : `COLL_LIMIT_HIGH; // RULE3
            loopback_partition_enable   <= ~cfg_data_q[`BIT_LOOPBACK_PART]; // RULE4
            late_collision_count_enable <= ~cfg_data_q[`BIT_LATE_COLL]; // RULE5
            restricted_reconnect_enable <= ~cfg_data_q[`BIT_RESTRICT_RECON]; // RULE6
            partition_disable           <= ~cfg_data_q[`BIT_PART_DISABLE]; // RULE7
            display_max_mode            <= cfg_data_q[`BIT_DISPLAY_MODE]; // RULE8
            bus_polarity_select         <= cfg_addr_q[`BIT_BUS_POLARITY]; // RULE10
            decoder_source_select       <= cfg_addr_q[`BIT_DECODER_SRC]; // RULE11
            // Flags a loader that broke the reserved pin; the value is still used
            reserved_option_error       <= loaded_q & ~cfg_addr_q[`BIT_RESERVED]; // RULE12
        end
    end

    // ****************************************************************
    // Transceiver selection per port
    // ****************************************************************
    reg  [3:0]  first_internal;
    wire [11:0] internal_d;

    always @* begin
        case ({cfg_addr_q[`BIT_BYPASS_HIGH], cfg_addr_q[`BIT_BYPASS_LOW]})
            2'b00:   first_internal = `FIRST_INT_00;
            2'b01:   first_internal = `FIRST_INT_01;
            2'b10:   first_internal = `FIRST_INT_10;
            default: first_internal = `FIRST_INT_11;
        endcase
    end

    // Entry i stands for port i+2; port 1 always uses the external interface
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi = gi + 1) begin : g_port
            localparam integer PORT_NUM = gi + 2;
            assign internal_d[gi] = (PORT_NUM >= first_internal); // RULE9
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn) begin
            internal_transceiver_ports <= 12'hfff;
        end else begin
            internal_transceiver_ports <= internal_d; // RULE9
        end
    end

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    reg        aw_full_q;
    reg        w_full_q;
    reg [7:0]  aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    wire       do_write;
    reg        wr_hit;

    assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;

    always @* begin
        case (aw_addr_q)
            `OFF_CFG_STATUS,
            `OFF_CFG_DERIVED,
            `OFF_LEARN_EN,
            `OFF_SECURITY_EN,
            `OFF_SOURCE_CHECK_EN,
            `OFF_DEST_CHECK_EN: wr_hit = 1'b1;
            default:            wr_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q     <= {s_axi_awaddr[7:2], 2'b00};
                aw_full_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                w_full_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            // Both channels reopen only after the response, so one write at a time
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Port security enables
    // ****************************************************************
    // A load wins over a software write in the same cycle
    wire [12:0] wr_value;

    assign wr_value = {(w_strb_q[1] ? w_data_q[12:8] : 5'h00),
                       (w_strb_q[0] ? w_data_q[7:0] : 8'h00)};

    function [12:0] merge_en;
        input [12:0] old_val;
        input [12:0] new_val;
        input [3:0]  strb;
        begin
            merge_en = {(strb[1] ? new_val[12:8] : old_val[12:8]),
                        (strb[0] ? new_val[7:0] : old_val[7:0])};
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            learn_enable        <= 13'h0000;
            security_enable     <= 13'h0000;
            source_check_enable <= 13'h0000;
            dest_check_enable   <= 13'h0000;
        end else if (load_edge) begin
            // Security mode sets every enable; otherwise software must set them
            learn_enable        <= data_sync[`BIT_SECURITY] ? 13'h0000 : `ALL_PORTS_EN; // RULE1
            security_enable     <= data_sync[`BIT_SECURITY] ? 13'h0000 : `ALL_PORTS_EN; // RULE1
            source_check_enable <= data_sync[`BIT_SECURITY] ? 13'h0000 : `ALL_PORTS_EN; // RULE1
            dest_check_enable   <= data_sync[`BIT_SECURITY] ? 13'h0000 : `ALL_PORTS_EN; // RULE1
        end else if (do_write) begin
            if (aw_addr_q == `OFF_LEARN_EN) begin
                learn_enable <= merge_en(learn_enable, wr_value, w_strb_q);
            end
            if (aw_addr_q == `OFF_SECURITY_EN) begin
                security_enable <= merge_en(security_enable, wr_value, w_strb_q);
            end
            if (aw_addr_q == `OFF_SOURCE_CHECK_EN) begin
                source_check_enable <= merge_en(source_check_enable, wr_value, w_strb_q);
            end
            if (aw_addr_q == `OFF_DEST_CHECK_EN) begin
                dest_check_enable <= merge_en(dest_check_enable, wr_value, w_strb_q);
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    reg [31:0] rd_value;
    reg        rd_hit;

    always @* begin
        rd_value = 32'h00000000;
        rd_hit   = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            `OFF_CFG_STATUS: begin
                rd_value[`STAT_DATA_LSB +: 8]  = cfg_data_q;
                rd_value[`STAT_ADDR_LSB +: 5]  = cfg_addr_q;
                rd_value[`STAT_RESV_ERR]       = reserved_option_error;
                rd_value[`STAT_LOADED]         = loaded_q;
                rd_value[`STAT_STROBE_LVL]     = strobe_sync;
                rd_value[`STAT_COUNT_LSB +: 8] = load_count_q;
            end
            `OFF_CFG_DERIVED: begin
                rd_value[`DER_GAP_LSB +: 3]       = gap_time_bits;
                rd_value[`DER_LIMIT_LSB +: 6]     = collision_limit;
                rd_value[`DER_INTERNAL_LSB +: 12] = internal_transceiver_ports;
            end
            `OFF_LEARN_EN:        rd_value[12:0] = learn_enable;
            `OFF_SECURITY_EN:     rd_value[12:0] = security_enable;
            `OFF_SOURCE_CHECK_EN: rd_value[12:0] = source_check_enable;
            `OFF_DEST_CHECK_EN:   rd_value[12:0] = dest_check_enable;
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_value;
                s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ### repeater_mode_load_config_defines.vh
`ifndef REPEATER_MODE_LOAD_CONFIG_DEFINES_VH
`define REPEATER_MODE_LOAD_CONFIG_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFF_CFG_STATUS      8'h00
`define OFF_CFG_DERIVED     8'h04
`define OFF_LEARN_EN        8'h08
`define OFF_SECURITY_EN     8'h0c
`define OFF_SOURCE_CHECK_EN 8'h10
`define OFF_DEST_CHECK_EN   8'h14

// ****************************************************************
// Data pin option positions
// ****************************************************************
`define BIT_SECURITY        0
`define BIT_GAP_TIME        1
`define BIT_COLL_LIMIT      2
`define BIT_LOOPBACK_PART   3
`define BIT_LATE_COLL       4
`define BIT_RESTRICT_RECON  5
`define BIT_PART_DISABLE    6
`define BIT_DISPLAY_MODE    7

// ****************************************************************
// Address pin option positions
// ****************************************************************
`define BIT_BYPASS_LOW      0
`define BIT_BYPASS_HIGH     1
`define BIT_BUS_POLARITY    2
`define BIT_DECODER_SRC     3
`define BIT_RESERVED        4

// ****************************************************************
// Status and derived register field positions
// ****************************************************************
`define STAT_DATA_LSB       0
`define STAT_ADDR_LSB       8
`define STAT_RESV_ERR       16
`define STAT_LOADED         17
`define STAT_STROBE_LVL     18
`define STAT_COUNT_LSB      24
`define DER_GAP_LSB         0
`define DER_LIMIT_LSB       8
`define DER_INTERNAL_LSB    16

// ****************************************************************
// Reset values, option figures and response codes
// ****************************************************************
`define RST_CFG_DATA        8'hff
`define RST_CFG_ADDR        5'h1f
`define GAP_BITS_LONG       3'h5
`define GAP_BITS_SHORT      3'h3
`define COLL_LIMIT_HIGH     6'h3f
`define COLL_LIMIT_LOW      6'h1f
`define ALL_PORTS_EN        13'h1fff
`define FIRST_INT_00        4'he
`define FIRST_INT_01        4'h6
`define FIRST_INT_10        4'h8
`define FIRST_INT_11        4'h2
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ### pin_sync.v
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for static pins and the load strobe
module pin_sync #(
    parameter WIDTH   = 1,
    parameter RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // Pins and synchronised copy
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_sync_q
);

    reg [WIDTH-1:0] meta_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q     <= {WIDTH{RST_VAL}};
            pin_sync_q <= {WIDTH{RST_VAL}};
        end else begin
            meta_q     <= pin_in;
            pin_sync_q <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ### config_checker_sva.sv
`timescale 1ns/100ps
`default_nettype none

module config_checker (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Load strobe and options
    input wire logic        config_load_strobe_n,
    input wire logic        core_reset_n,
    input wire logic        security_select,
    input wire logic [2:0]  gap_time_bits,
    input wire logic [5:0]  collision_limit,
    input wire logic [11:0] internal_transceiver_ports,
    input wire logic        display_max_mode,
    input wire logic [12:0] learn_enable,
    input wire logic [12:0] dest_check_enable,
    // Register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_HOLD_RESET: assert property ((!config_load_strobe_n)[*5] |-> !core_reset_n)
        else $error("core reset not held");
    AST_RUN: assert property (config_load_strobe_n[*5] |-> core_reset_n)
        else $error("core reset stuck");
    AST_HOLD_OPTS: assert property (config_load_strobe_n[*6] |->
        $stable(gap_time_bits) && $stable(collision_limit) && $stable(display_max_mode))
        else $error("options moved");
    AST_GAP: assert property (gap_time_bits == 3'h5 || gap_time_bits == 3'h3)
        else $error("bad gap time");
    AST_LIMIT: assert property (collision_limit == 6'h3f || collision_limit == 6'h1f)
        else $error("bad collision limit");
    AST_PORTS: assert property (internal_transceiver_ports inside
        {12'h000, 12'hff0, 12'hfc0, 12'hfff})
        else $error("bad port set");
    AST_SEC_LOAD: assert property ($fell(security_select) |->
        learn_enable == 13'h1fff && dest_check_enable == 13'h1fff)
        else $error("enables not set");
    AST_WBLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write not blocked");
    AST_RANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule

`default_nettype wire

// ### strap_loader.sv
`timescale 1ns/100ps
`default_nettype none

module strap_loader (
    // Clock
    input wire logic   aclk,
    // Option pins
    output logic       config_load_strobe_n,
    output logic [7:0] cfg_data_pins,
    output logic [4:0] cfg_addr_pins
);
    // ********
    // Processor-write style loader
    // ********
    initial begin
        {config_load_strobe_n, cfg_data_pins, cfg_addr_pins} = 14'h3fff;
    end

    task present(input logic [7:0] d, input logic [4:0] a);
        @(posedge aclk);
        cfg_data_pins <= d;
        cfg_addr_pins <= a;
        config_load_strobe_n <= 1'b0;
    endtask

    task release_strobe();
        @(posedge aclk);
        config_load_strobe_n <= 1'b1;
        repeat (4) @(posedge aclk);
        cfg_data_pins <= ~cfg_data_pins;
        cfg_addr_pins <= ~cfg_addr_pins;
    endtask
endmodule

`default_nettype wire

// ### test_repeater_mode_load_config.sv
`timescale 1ns/100ps
`default_nettype none

module test_repeater_mode_load_config;
    logic        aclk, aresetn;
    wire logic   config_load_strobe_n;
    wire logic [7:0] cfg_data_pins;
    wire logic [4:0] cfg_addr_pins;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic   core_reset_n, security_select, loopback_partition_enable;
    wire logic   late_collision_count_enable, restricted_reconnect_enable, partition_disable;
    wire logic   display_max_mode, bus_polarity_select, decoder_source_select, reserved_option_error;
    wire logic [2:0]  gap_time_bits;
    wire logic [5:0]  collision_limit;
    wire logic [11:0] internal_transceiver_ports;
    wire logic [12:0] learn_enable, security_enable, source_check_enable, dest_check_enable;
    integer      failures, checks_done;
    logic [1:0]  resp;
    logic [31:0] rd;

    strap_loader ldr (.aclk, .config_load_strobe_n, .cfg_data_pins, .cfg_addr_pins);

    repeater_mode_load_config uut (
        .aclk, .aresetn, .config_load_strobe_n, .cfg_data_pins, .cfg_addr_pins,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .core_reset_n, .security_select, .gap_time_bits, .collision_limit,
        .loopback_partition_enable, .late_collision_count_enable,
        .restricted_reconnect_enable, .partition_disable, .display_max_mode,
        .internal_transceiver_ports, .bus_polarity_select, .decoder_source_select,
        .reserved_option_error, .learn_enable, .security_enable,
        .source_check_enable, .dest_check_enable);

    // ********
    // Shared tasks
    // ********
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task timed_out(input integer n);
        if (n == 40) begin
            failures++;
            $display("[FAIL] bus_wait expected 1 seen 0");
            close_out();
        end
    endtask

    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        integer n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        timed_out(n);
    endtask

    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        integer n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        timed_out(n);
    endtask

    task do_load(input logic [7:0] d, input logic [4:0] a);
        logic [11:0] ports;
        ports = (a[1:0] == 2'h3) ? 12'hfff : (a[1:0] == 2'h2) ? 12'hfc0 :
                (a[1:0] == 2'h1) ? 12'hff0 : 12'h000;
        ldr.present(d, a);
        repeat (5) @(posedge aclk);
        check("core_reset_n low", core_reset_n, 0);
        ldr.release_strobe();
        repeat (6) @(posedge aclk);
        check("core_reset_n high", core_reset_n, 1);
        check("security_select", security_select, d[0]);
        check("learn_enable", learn_enable, d[0] ? 0 : 13'h1fff);
        check("security_enable", security_enable, d[0] ? 0 : 13'h1fff);
        check("source_check", source_check_enable, d[0] ? 0 : 13'h1fff);
        check("dest_check", dest_check_enable, d[0] ? 0 : 13'h1fff);
        check("gap_time_bits", gap_time_bits, d[1] ? 3'h3 : 3'h5);
        check("collision_limit", collision_limit, d[2] ? 6'h1f : 6'h3f);
        check("loopback_part", loopback_partition_enable, !d[3]);
        check("late_collision", late_collision_count_enable, !d[4]);
        check("restricted_recon", restricted_reconnect_enable, !d[5]);
        check("partition_disable", partition_disable, !d[6]);
        check("display_max_mode", display_max_mode, d[7]);
        check("internal_ports", internal_transceiver_ports, ports);
        check("bus_polarity", bus_polarity_select, a[2]);
        check("decoder_source", decoder_source_select, a[3]);
        check("reserved_error", reserved_option_error, !a[4]);
    endtask

    // ********
    // Scenarios
    // ********
    task t_option_table();
        logic [7:0] dt [4];
        logic [4:0] at [4];
        dt = '{8'h00, 8'hff, 8'h5a, 8'ha5};
        at = '{5'h10, 5'h1f, 5'h0d, 5'h16};
        for (int i = 0; i < 4; i++)
            do_load(dt[i], at[i]);
    endtask

    task t_soft_enables();
        do_load(8'hff, 5'h1f);
        axi_write(8'h08, 32'h0000_1234, resp);
        check("enable write resp", resp, 2'h0);
        check("learn_enable sw", learn_enable, 13'h1234);
        axi_read(8'h08, rd, resp);
        check("enable read", rd, 32'h0000_1234);
        axi_write(8'h40, 32'hffff_ffff, resp);
        check("unmapped write resp", resp, 2'h2);
        axi_read(8'h40, rd, resp);
        check("unmapped read resp", resp, 2'h2);
        check("unmapped read data", rd, 32'h0);
        do_load(8'hfe, 5'h1f);
    endtask

    initial begin
        failures = 0;
        checks_done = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 54'h0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_option_table();
        t_soft_enables();
        close_out();
    end
endmodule

bind repeater_mode_load_config config_checker chk_i (
    .aclk, .aresetn, .config_load_strobe_n, .core_reset_n, .security_select,
    .gap_time_bits, .collision_limit, .internal_transceiver_ports, .display_max_mode,
    .learn_enable, .dest_check_enable, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

`default_nettype wire
